/* File: rtl/sms_pkg.sv */
/*
  Shared constants and types for the 8-bit serial shift core.
  Assumes one system clock; control bits arrive as plain ports.
*/
// Overview of operation
// - Enable dedicates the four serial pins
// - Status read then data write starts transfer
// - Completed byte to receive buffer; writes load transmit
// - Master bit picks master or slave
// - Empty shifter takes written byte at once; slave loads it only at select or byte end
// - Master drives clock from divider; slave receives
// - Automatic select low during transfer, high idle
// - Select low in master raises fault, aborts
// - Fault with enable requests interrupt
// - Half clock period before serial clock starts
// - Config change in master aborts transfer
// - Slave select high forces slave idle
// - Deselected slave floats output, ignores clock
// - Phase chooses latch and shift edges; order
// - Polarity inverts serial clock
// - Slave first bit at select or first edge
// - Eighth shift completes, sets receive full
// - Phase one: select leads, ends after bit eight
// - Phase zero: select trails by half period
// - Phase one back-to-back without pause
// - Polarity zero idles low, one high
// - Divisor is (prescale+1) times 2^(rate+1)
// - Status read then control write clears fault
// - Single-wire mode uses one data pin
package sms_pkg;
  // ****************************************
  // Sizes and counts
  // ****************************************
  localparam int          DATA_W     = 8;
  localparam int          RXQ_DEPTH  = 2;
  localparam int          DIV_W      = 12;
  localparam int          CFG_W      = 12;
  localparam logic [4:0]  LAST_EDGE  = 5'h10;
  localparam logic [3:0]  RATE_MAX   = 4'h8;
  localparam logic [7:0]  DATA_RST   = 8'h00;
  localparam int          CLK_PER_NS = 100;

  typedef enum logic [1:0] {
    SMS_IDLE  = 2'b00,
    SMS_LEAD  = 2'b01,
    SMS_SHIFT = 2'b11,
    SMS_TRAIL = 2'b10
  } sms_mstate_t;
endpackage : sms_pkg

/* File: rtl/sms_baud_div.sv */
/*
  Half-bit tick generator for master mode.
  Assumes run is held high for the whole transfer.
*/
`timescale 1ns/1ps
module sms_baud_div (
  input  wire logic       i_clk_sys,   // System clock
  input  wire logic       i_rst,       // Sync reset
  input  wire logic       i_clk_en,    // Freeze when low
  input  wire logic       i_run,       // Divider active
  input  wire logic [2:0] i_prescale,  // Prescale field
  input  wire logic [3:0] i_rate,      // Rate select field
  output logic            o_half_tick  // One pulse per half bit
);
  typedef struct packed {
    logic [sms_pkg::DIV_W-1:0] cnt;
  } sms_div_state_t;

  sms_div_state_t r, n;
  logic [3:0]                rate_c;
  logic [sms_pkg::DIV_W-1:0] limit;

  // Reserved rate codes fall back to the largest divisor
  assign rate_c = (i_rate > sms_pkg::RATE_MAX) ? sms_pkg::RATE_MAX : i_rate;
  // Half of (prescale+1)*2^(rate+1) system cycles
  assign limit = (sms_pkg::DIV_W'({1'b0, i_prescale} + 4'h1) << rate_c)
               - sms_pkg::DIV_W'(1);
  assign o_half_tick = i_run && (r.cnt == limit);

  always_comb begin
    n = r;
    if (!i_run || o_half_tick) begin
      n.cnt = '0;
    end else begin
      n.cnt = r.cnt + sms_pkg::DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      r <= '0;
    end else if (i_clk_en) begin
      r <= n;
    end
  end
endmodule : sms_baud_div

/* File: rtl/sms_rx_fifo.sv */
/*
  Two-entry receive buffer with valid/ready on both sides.
  Assumes the filler drops its word when in_ready is low.
*/
`timescale 1ns/1ps
module sms_rx_fifo (
  input  wire logic                      i_clk_sys,   // System clock
  input  wire logic                      i_rst,       // Sync reset
  input  wire logic                      i_clk_en,    // Freeze when low
  input  wire logic                      i_in_valid,  // Word offered
  output logic                           o_in_ready,  // Space left
  input  wire logic [sms_pkg::DATA_W-1:0] i_in_data,  // Word in
  output logic                           o_out_valid, // Word held
  input  wire logic                      i_out_ready, // Consumer takes
  output logic [sms_pkg::DATA_W-1:0]     o_out_data   // Oldest word
);
  typedef struct packed {
    logic [sms_pkg::RXQ_DEPTH-1:0][sms_pkg::DATA_W-1:0] mem;
    logic                                               wp;
    logic                                               rp;
    logic [1:0]                                         cnt;
  } sms_fifo_state_t;

  sms_fifo_state_t r, n;
  logic            push, pop;

  assign o_in_ready  = (r.cnt != 2'(sms_pkg::RXQ_DEPTH));
  assign o_out_valid = (r.cnt != 2'h0);
  assign o_out_data  = r.mem[r.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = i_in_data;
      n.wp        = ~r.wp;
    end
    if (pop) begin
      n.rp = ~r.rp;
    end
    n.cnt = r.cnt + 2'(push) - 2'(pop);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      r <= '0;
    end else if (i_clk_en) begin
      r <= n;
    end
  end
endmodule : sms_rx_fifo

/* File: rtl/sms_core.sv */
/*
  Serial shift core, master or slave, with pins split into in/out/oe.
  Assumes software strobes are one-cycle pulses on i_clk_sys; pins are
  asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
module sms_core (
  input  wire logic       i_clk_sys,                 // 10 MHz system clock
  input  wire logic       i_rst,                     // Sync reset, high
  input  wire logic       i_clk_en,                  // Freeze when low
  input  wire logic       i_module_enable,           // Block enable
  input  wire logic       i_master_select,           // 1 master, 0 slave
  input  wire logic       i_clock_polarity,          // Idle level of clock
  input  wire logic       i_clock_phase,             // Clock format
  input  wire logic       i_low_bit_first,           // Shift order
  input  wire logic       i_select_output_enable,    // Auto select out
  input  wire logic       i_fault_detect_enable,     // Fault detect
  input  wire logic       i_single_wire_select,      // One data pin
  input  wire logic       i_single_wire_direction,   // Drive that pin
  input  wire logic       i_receive_fault_irq_enable,// Irq enable
  input  wire logic [2:0] i_prescale_field,          // Prescale
  input  wire logic [3:0] i_rate_select_field,       // Rate select
  input  wire logic       i_status_rd,               // Status read pulse
  input  wire logic       i_ctrl1_wr,                // Control write pulse
  input  wire logic       i_data_wr,                 // Data write pulse
  input  wire logic [7:0] i_data_wdata,              // Data to send
  input  wire logic       i_data_rd,                 // Data read pulse
  output logic      [7:0] o_data_rdata,              // Received byte
  output logic            o_transmit_empty_flag,     // Tx buffer free
  output logic            o_receive_full_flag,       // Rx byte waiting
  output logic            o_fault_flag,              // Mode fault
  output logic            o_master_active,           // Acting master
  output logic            o_irq_request,             // Interrupt level
  input  wire logic       i_serial_clock_pin,        // Clock pin in
  output logic            o_serial_clock_pin,        // Clock pin out
  output logic            o_serial_clock_pin_oe,     // Clock pin drive
  input  wire logic       i_mosi,                    // MOSI in
  output logic            o_mosi,                    // MOSI out
  output logic            o_mosi_oe,                 // MOSI drive
  input  wire logic       i_miso,                    // MISO in
  output logic            o_miso,                    // MISO out
  output logic            o_miso_oe,                 // MISO drive
  input  wire logic       i_ss_n,                    // Select in
  output logic            o_ss_n,                    // Select out
  output logic            o_ss_n_oe                  // Select drive
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                 sck_s1, sck_s2, sck_s3;
    logic                 mosi_s1, mosi_s2;
    logic                 miso_s1, miso_s2;
    logic                 ss_s1, ss_s2, ss_s3;
    sms_pkg::sms_mstate_t st;
    logic [4:0]           edge_cnt;
    logic                 sck_lvl;
    logic [7:0]           sr;
    logic                 lat;
    logic                 dout;
    logic [7:0]           tx_buf;
    logic                 tx_full;
    logic                 tef_seen;
    logic                 fault;
    logic                 fclr_armed;
    logic [sms_pkg::CFG_W+1:0] cfg_prev;
  } sms_core_state_t;

  localparam sms_core_state_t RST = '{
    ss_s1: 1'b1, ss_s2: 1'b1, ss_s3: 1'b1,
    st: sms_pkg::SMS_IDLE, tx_buf: sms_pkg::DATA_RST,
    sr: sms_pkg::DATA_RST, default: '0};

  sms_core_state_t r, n;

  logic                      m_eff, half_tick, done, rx_ready, rx_valid;
  logic                      din, ev, en_odd, smp_edge, cfg_chg, fault_set;
  logic                      abort, wr_ok;
  logic [7:0]                rx_word;
  logic [4:0]                en;
  logic [sms_pkg::CFG_W-1:0] cfg;

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b,
                                          input logic lsbf);
    // Shift direction follows the order: right with entry at bit 7, or left with entry at bit 0
    shift_in = lsbf ? {b, s[7:1]} : {s[6:0], b};
  endfunction : shift_in

  function automatic logic head(input logic [7:0] s, input logic lsbf);
    head = lsbf ? s[0] : s[7];
  endfunction : head

  // ****************************************
  // Mode and configuration watch
  // ****************************************
  assign m_eff = i_module_enable && i_master_select && !r.fault;
  assign cfg = {i_clock_polarity, i_clock_phase, i_select_output_enable,
                i_low_bit_first, i_fault_detect_enable, i_single_wire_select,
                i_single_wire_direction && i_single_wire_select,
                i_prescale_field, i_rate_select_field[3:2]};
  assign cfg_chg = ({cfg, i_rate_select_field[1:0]} != r.cfg_prev);
  assign fault_set = i_module_enable && i_master_select && !r.fault &&
                     i_fault_detect_enable && !i_select_output_enable &&
                     !r.ss_s2;
  assign abort = !m_eff || fault_set || cfg_chg;
  assign wr_ok = i_data_wr && r.tef_seen && !r.tx_full;

  // Sample pin: single-wire mode samples MOSI as master and MISO as slave
  always_comb begin
    if (m_eff) begin
      din = i_single_wire_select ? r.mosi_s2 : r.miso_s2;
    end else begin
      din = i_single_wire_select ? r.miso_s2 : r.mosi_s2;
    end
  end

  sms_baud_div u_div (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_clk_en    (i_clk_en),
    .i_run       (m_eff && (r.st != sms_pkg::SMS_IDLE)),
    .i_prescale  (i_prescale_field),
    .i_rate      (i_rate_select_field),
    .o_half_tick (half_tick)
  );

  // ****************************************
  // Edge bookkeeping shared by both roles
  // ****************************************
  always_comb begin
    if (m_eff) begin
      ev = (r.st == sms_pkg::SMS_LEAD || r.st == sms_pkg::SMS_SHIFT) && half_tick;
    end else begin
      // Deselected slave ignores the clock
      ev = i_module_enable && !r.ss_s2 && (r.sck_s2 != r.sck_s3);
    end
    en       = r.edge_cnt + 5'h01;
    en_odd   = en[0];
    smp_edge = i_clock_phase ? !en_odd : en_odd;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n      = r;
    done   = 1'b0;
    n.sck_s1  = i_serial_clock_pin;
    n.sck_s2  = r.sck_s1;
    n.sck_s3  = r.sck_s2;
    n.mosi_s1 = i_mosi;
    n.mosi_s2 = r.mosi_s1;
    n.miso_s1 = i_miso;
    n.miso_s2 = r.miso_s1;
    n.ss_s1   = i_ss_n;
    n.ss_s2   = r.ss_s1;
    n.ss_s3   = r.ss_s2;
    n.cfg_prev = {cfg, i_rate_select_field[1:0]};

    // Software side of the status/data handshake
    if (i_status_rd && !r.tx_full) begin
      n.tef_seen = 1'b1;
    end
    if (i_status_rd && r.fault) begin
      n.fclr_armed = 1'b1;
    end

    // Shift engine, common to both roles
    if (ev) begin
      n.edge_cnt = en;
      if (m_eff) begin
        n.sck_lvl = ~r.sck_lvl;
      end
      if (smp_edge) begin
        n.lat = din;
        if (en == sms_pkg::LAST_EDGE) begin
          n.sr   = shift_in(r.sr, din, i_low_bit_first);
          done   = 1'b1;
        end
      end else if (i_clock_phase && en == 5'h01) begin
        n.dout = head(r.sr, i_low_bit_first);
      end else begin
        n.sr   = shift_in(r.sr, r.lat, i_low_bit_first);
        n.dout = head(n.sr, i_low_bit_first);
        if (en == sms_pkg::LAST_EDGE) begin
          done = 1'b1;
        end
      end
    end
    rx_word = n.sr; // Taken before a slave reload replaces the shifter

    if (m_eff) begin
      case (r.st)
        sms_pkg::SMS_IDLE: begin
          if (r.tx_full) begin
            n.sr       = r.tx_buf;
            n.dout     = head(r.tx_buf, i_low_bit_first);
            n.tx_full  = 1'b0;
            n.edge_cnt = 5'h00;
            n.st       = sms_pkg::SMS_LEAD;
          end
        end
        sms_pkg::SMS_LEAD: begin
          if (half_tick) begin
            n.st = sms_pkg::SMS_SHIFT;
          end
        end
        sms_pkg::SMS_SHIFT: begin
          if (ev && en == sms_pkg::LAST_EDGE) begin
            n.st = sms_pkg::SMS_TRAIL;
          end
        end
        sms_pkg::SMS_TRAIL: begin
          if (half_tick) begin
            if (i_clock_phase && n.tx_full) begin
              n.sr       = r.tx_buf;
              n.dout     = head(r.tx_buf, i_low_bit_first);
              n.sck_lvl  = ~r.sck_lvl;
              n.tx_full  = 1'b0;
              n.edge_cnt = 5'h01;
              n.st       = sms_pkg::SMS_SHIFT;
            end else begin
              n.st = sms_pkg::SMS_IDLE;
            end
          end
        end
        default: begin
          n.st = sms_pkg::SMS_IDLE;
        end
      endcase
    end else begin
      n.st      = sms_pkg::SMS_IDLE;
      n.sck_lvl = 1'b0;
      if (r.ss_s2) begin
        n.edge_cnt = 5'h00;
      end else if ((r.ss_s3 || done) && i_module_enable) begin
        // Selection or a finished byte reloads from the transmit buffer
        if (r.tx_full) begin
          n.sr      = r.tx_buf;
          n.tx_full = 1'b0;
        end
        n.edge_cnt = 5'h00;
        n.dout     = head(n.sr, i_low_bit_first);
      end
    end

    // Aborts drop the transfer and return the master to idle
    if (abort && r.st != sms_pkg::SMS_IDLE) begin
      n.st       = sms_pkg::SMS_IDLE;
      n.sck_lvl  = 1'b0;
      n.edge_cnt = 5'h00;
      done       = 1'b0;
    end

    // Write lands after any reload so a queued byte is never overwritten
    if (wr_ok) begin
      n.tx_buf   = i_data_wdata;
      n.tx_full  = 1'b1;
      n.tef_seen = 1'b0;
    end else if (i_data_wr) begin
      n.tef_seen = 1'b0;
    end

    // Set beats clear when both land in one cycle
    if (i_ctrl1_wr) begin
      n.fclr_armed = 1'b0;
      if (r.fclr_armed) begin
        n.fault = 1'b0;
      end
    end
    if (fault_set) begin
      n.fault = 1'b1;
    end
  end

  // ****************************************
  // Receive buffer
  // ****************************************
  // A full buffer drops the new byte, as an overrun would
  sms_rx_fifo u_rxq (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_clk_en    (i_clk_en),
    .i_in_valid  (done),
    .o_in_ready  (rx_ready),
    .i_in_data   (rx_word),
    .o_out_valid (rx_valid),
    .i_out_ready (i_data_rd),
    .o_out_data  (o_data_rdata)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      r <= RST;
    end else if (i_clk_en) begin
      r <= n;
    end
  end

  // ****************************************
  // Pins and flags
  // ****************************************
  assign o_transmit_empty_flag = !r.tx_full;
  assign o_receive_full_flag   = rx_valid;
  assign o_fault_flag          = r.fault;
  assign o_master_active       = m_eff;
  assign o_irq_request = i_receive_fault_irq_enable &&
                         (r.fault || rx_valid);

  // Clock output idles at the polarity level
  assign o_serial_clock_pin    = r.sck_lvl ^ i_clock_polarity;
  assign o_serial_clock_pin_oe = m_eff;
  assign o_mosi    = r.dout;
  assign o_mosi_oe = m_eff &&
                     (!i_single_wire_select || i_single_wire_direction);
  assign o_miso    = r.dout;
  // Faulted block keeps every output off
  assign o_miso_oe = i_module_enable && !i_master_select && !r.fault &&
                     !r.ss_s2 &&
                     (!i_single_wire_select || i_single_wire_direction);
  assign o_ss_n    = (r.st == sms_pkg::SMS_IDLE);
  assign o_ss_n_oe = m_eff && i_fault_detect_enable && i_select_output_enable;
endmodule : sms_core

/* File: sim/sms_chk.sv */
/*
  Concurrent checks on the ports of sms_core, bound to every instance.
  Assumes i_clk_en is held high and single-wire mode is off.
*/
`timescale 1ns/1ps
module sms_chk (
  input logic       i_clk_sys,              // Clock
  input logic       i_rst,                  // Reset
  input logic       i_module_enable,        // Enable
  input logic       i_master_select,        // Master
  input logic       i_clock_polarity,       // Polarity
  input logic       i_select_output_enable, // Auto select
  input logic       i_fault_detect_enable,  // Fault detect
  input logic       i_receive_fault_irq_enable, // Irq enable
  input logic [2:0] i_prescale_field,       // Prescale
  input logic [3:0] i_rate_select_field,    // Rate
  input logic       i_status_rd,            // Status read
  input logic       i_data_wr,              // Data write
  input logic       i_ss_n,                 // Select wire
  input logic       o_transmit_empty_flag,  // Tx free
  input logic       o_receive_full_flag,    // Rx held
  input logic       o_fault_flag,           // Fault
  input logic       o_master_active,        // Master
  input logic       o_irq_request,          // Irq
  input logic       o_serial_clock_pin,     // Clock out
  input logic       o_serial_clock_pin_oe,  // Clock drive
  input logic       o_mosi_oe,              // Mosi drive
  input logic       o_miso_oe,              // Miso drive
  input logic       o_ss_n,                 // Select out
  input logic       o_ss_n_oe               // Select drive
);
  // ****************************************
  // Helper state
  // ****************************************
  logic        arm_r;
  logic        prev_r;
  logic        seen_r;
  logic [12:0] gap_r;
  logic [12:0] half;
  logic        tog;
  assign tog  = prev_r != o_serial_clock_pin;
  assign half = (13'(i_prescale_field) + 13'h1) <<
                ((i_rate_select_field > 4'h8) ? 4'h8 : i_rate_select_field);

  always_ff @(posedge i_clk_sys) begin
    prev_r <= o_serial_clock_pin;
    if (i_rst || i_data_wr) arm_r <= 1'b0;
    else if (i_status_rd && o_transmit_empty_flag) arm_r <= 1'b1;
    if (i_rst || o_ss_n || !o_master_active) begin
      seen_r <= 1'b0;
      gap_r  <= 13'h0;
    end else if (tog) begin
      seen_r <= 1'b1;
      gap_r  <= 13'h1;
    end else begin
      gap_r  <= gap_r + 13'h1;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // ****************************************
  // Assertions
  // ****************************************
  pins_released_a: assert property (!i_module_enable |-> !o_serial_clock_pin_oe
    && !o_mosi_oe && !o_miso_oe && !o_ss_n_oe) else $error("pin driven while disabled");
  unarmed_write_a: assert property (i_data_wr && !arm_r && o_transmit_empty_flag
    |=> o_transmit_empty_flag) else $error("unarmed write accepted");
  auto_select_a: assert property (o_master_active && i_select_output_enable
    && i_fault_detect_enable |-> o_ss_n_oe) else $error("select not driven");
  fault_raise_a: assert property ((o_master_active && i_fault_detect_enable
    && !i_select_output_enable && !i_ss_n)[*3] |-> ##[1:2] o_fault_flag)
    else $error("fault not raised");
  fault_quiet_a: assert property (o_fault_flag |-> !o_master_active
    && !o_serial_clock_pin_oe && !o_mosi_oe && !o_miso_oe) else $error("fault pins");
  fault_irq_a: assert property (o_fault_flag && i_receive_fault_irq_enable
    |-> o_irq_request) else $error("fault irq missing");
  slave_float_a: assert property ((!i_master_select && i_ss_n)[*4]
    |-> !o_miso_oe) else $error("deselected slave drives");
  idle_level_a: assert property (o_master_active && i_select_output_enable
    && i_fault_detect_enable && o_ss_n && $past(o_ss_n) && $stable(i_clock_polarity)
    |-> o_serial_clock_pin == i_clock_polarity) else $error("idle clock level");
  half_bit_a: assert property (seen_r && tog && !o_ss_n && i_select_output_enable
    && i_fault_detect_enable |-> gap_r == half) else $error("half period wrong");

  cover property (o_fault_flag);
  cover property ($fell(o_ss_n));
  cover property (!i_master_select && o_receive_full_flag);
endmodule : sms_chk

bind sms_core sms_chk u_chk (.*);

/* File: sim/sms_far_dev.sv */
/*
  Behavioural far-side serial slave used in master runs.
  Assumes edges are counted from the fall of select.
*/
`timescale 1ns/1ps
module sms_far_dev (
  input  wire logic       i_sck,   // Clock wire
  input  wire logic       i_ss_n,  // Select wire
  input  wire logic       i_mosi,  // Data in
  input  wire logic       i_pha,   // Phase
  input  wire logic       i_lsb,   // Low bit first
  input  wire logic [7:0] i_tx,    // Byte to return
  output logic            o_miso,  // Data out
  output logic      [7:0] o_rx     // Byte taken
);
  logic [7:0] sh;
  logic       bit_out;
  logic       last = 1'b0;
  int         n;
  assign bit_out = i_lsb ? sh[0] : sh[7];
  // A released line shows the inverse, so a held bit cannot pass
  assign o_miso  = i_ss_n ? ~last : bit_out;
  always @* if (!i_ss_n) last = bit_out;
  always @(negedge i_ss_n) begin
    n  = 0;
    sh = i_tx;
  end
  always @(i_sck) if (!i_ss_n) begin
    if (n == 16) begin  // Select still low: next byte at once
      n  = 0;
      sh = i_tx;
    end
    n = n + 1;
    if (n[0] ^ i_pha) o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
    else if (n > 1) sh = i_lsb ? sh >> 1 : sh << 1;
  end
endmodule : sms_far_dev

/* File: sim/spi_master_slave_shift_core_test.sv */
/*
  Self-checking bench for sms_core: master runs against sms_far_dev,
  slave run driven by the bench. Assumes sms_chk is bound.
*/
`timescale 1ns/1ps
module spi_master_slave_shift_core_test;
  logic       i_clk_sys, i_rst, i_clk_en, i_module_enable, i_master_select;
  logic       i_clock_polarity, i_clock_phase, i_low_bit_first, i_select_output_enable;
  logic       i_fault_detect_enable, i_single_wire_select, i_single_wire_direction;
  logic       i_receive_fault_irq_enable, i_status_rd, i_ctrl1_wr, i_data_wr, i_data_rd;
  logic [2:0] i_prescale_field;
  logic [3:0] i_rate_select_field;
  logic [7:0] i_data_wdata, o_data_rdata, far_tx, far_rx, got;
  logic       o_transmit_empty_flag, o_receive_full_flag, o_fault_flag, o_master_active;
  logic       o_irq_request, o_serial_clock_pin, o_serial_clock_pin_oe, o_mosi, o_mosi_oe;
  logic       o_miso, o_miso_oe, o_ss_n, o_ss_n_oe, tb_sck, tb_mosi, tb_ss_n, far_miso;
  int         err_count, n_checks;
  wire i_serial_clock_pin = o_serial_clock_pin_oe ? o_serial_clock_pin : tb_sck;
  wire i_mosi = o_mosi_oe ? o_mosi : tb_mosi;
  wire i_miso = o_miso_oe ? o_miso : far_miso;
  wire i_ss_n = o_ss_n_oe ? o_ss_n : tb_ss_n;

  sms_core u_dut (.*);
  sms_far_dev u_far (.i_sck(i_serial_clock_pin), .i_ss_n(i_ss_n), .i_mosi(i_mosi),
    .i_pha(i_clock_phase), .i_lsb(i_low_bit_first), .i_tx(far_tx), .o_miso(far_miso),
    .o_rx(far_rx));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results;
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : cyc
  task automatic wait_for(input int w);
    int i;
    for (i = 0; i < 3000; i++) begin
      if ((w == 0 && o_receive_full_flag === 1'b1) || (w == 1 && o_ss_n === 1'b1)
          || (w == 2 && o_transmit_empty_flag === 1'b1)) break;
      cyc(1);
    end
    if (i == 3000) begin
      err_count++;
      results();
    end
  endtask : wait_for
  task automatic put(input logic [7:0] b);  // Status read, then write a cycle later
    i_status_rd  <= 1'b1;
    cyc(1);
    i_status_rd  <= 1'b0;
    i_data_wr    <= 1'b1;
    i_data_wdata <= b;
    cyc(1);
    i_data_wr    <= 1'b0;
    cyc(1);
  endtask : put
  task automatic pop;
    i_data_rd <= 1'b1;
    cyc(1);
    i_data_rd <= 1'b0;
    cyc(1);
  endtask : pop
  task automatic cfg(input logic m, p, c, l);
    i_module_enable  <= 1'b1;
    i_master_select  <= m;
    i_clock_phase    <= p;
    i_clock_polarity <= c;
    i_low_bit_first  <= l;
    cyc(4);
  endtask : cfg

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic run_unarmed;
    i_data_wr    <= 1'b1;
    i_data_wdata <= 8'hE7;
    cyc(1);
    i_data_wr    <= 1'b0;
    cyc(20);
    chk({o_transmit_empty_flag, o_ss_n}, 8'h03);
  endtask : run_unarmed
  task automatic run_master(input logic p, c, l);
    cfg(1'b1, p, c, l);
    far_tx = 8'h35;
    put(8'hC1);
    cyc(4);
    chk(o_ss_n, 8'h00);
    wait_for(0);
    chk(o_data_rdata, 8'h35);
    wait_for(1);
    chk(far_rx, 8'hC1);
    chk(o_serial_clock_pin, {7'h0, c});
    pop();
  endtask : run_master
  task automatic run_b2b;  // No reads between transfers: buffer fills, third byte is dropped
    cfg(1'b1, 1'b1, 1'b0, 1'b0);
    far_tx = 8'h35;
    put(8'hC1);
    wait_for(2);
    put(8'h5E);
    cyc(6);
    wait_for(1);
    chk(far_rx, 8'h5E);
    far_tx = 8'h77;
    put(8'h12);
    cyc(6);
    wait_for(1);
    chk(far_rx, 8'h12);
    repeat (2) begin
      chk(o_data_rdata, 8'h35);
      pop();
    end
    chk(o_receive_full_flag, 8'h00);
  endtask : run_b2b
  task automatic run_abort;
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    put(8'h5A);
    cyc(20);
    i_clock_polarity <= 1'b1;
    cyc(3);
    chk(o_ss_n, 8'h01);
    cyc(80);
    chk(o_receive_full_flag, 8'h00);
  endtask : run_abort
  task automatic run_fault;
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    i_select_output_enable     <= 1'b0;
    i_receive_fault_irq_enable <= 1'b1;
    tb_ss_n <= 1'b0;
    cyc(6);
    chk({o_fault_flag, o_master_active, o_irq_request, o_mosi_oe}, 8'h0A);
    tb_ss_n <= 1'b1;
    cyc(4);
    i_status_rd <= 1'b1;
    cyc(1);
    i_status_rd <= 1'b0;
    i_ctrl1_wr  <= 1'b1;
    cyc(1);
    i_ctrl1_wr  <= 1'b0;
    i_receive_fault_irq_enable <= 1'b0;
    cyc(3);
    chk({o_fault_flag, o_master_active}, 8'h01);
    i_module_enable <= 1'b0;
    cyc(1);
    chk({o_serial_clock_pin_oe, o_mosi_oe, o_ss_n_oe}, 8'h00);
  endtask : run_fault
  task automatic run_slave;
    int         i;
    logic [7:0] pat = 8'h4B;
    cfg(1'b0, 1'b0, 1'b0, 1'b0);
    put(8'h96);
    cyc(5);
    chk(o_miso_oe, 8'h00);
    tb_ss_n <= 1'b0;  // Select low before the first edge
    cyc(8);
    chk(o_miso, 8'h01);
    for (i = 7; i >= 0; i--) begin
      tb_mosi <= pat[i];
      cyc(8);
      got = {got[6:0], o_miso};
      tb_sck <= 1'b1;
      cyc(8);
      tb_sck <= 1'b0;
    end
    cyc(8);
    tb_ss_n <= 1'b1;  // Raised only after the eighth bit
    chk(got, 8'h96);
    wait_for(0);
    chk(o_data_rdata, 8'h4B);
    pop();
  endtask : run_slave

  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    {i_master_select, i_clock_polarity, i_clock_phase, i_low_bit_first} = '0;
    {i_single_wire_select, i_single_wire_direction, i_receive_fault_irq_enable} = '0;
    {i_status_rd, i_ctrl1_wr, i_data_wr, i_data_rd, tb_sck, tb_mosi} = '0;
    {i_rst, i_clk_en, i_module_enable, tb_ss_n} = '1;
    {i_select_output_enable, i_fault_detect_enable} = '1;
    i_prescale_field    = 3'h1;
    i_rate_select_field = 4'h1;
    i_data_wdata = 8'h00;
    err_count    = 0;
    n_checks     = 0;
    cyc(4);
    i_rst <= 1'b0;
    cyc(2);
    run_unarmed();
    i_master_select <= 1'b1;
    for (int k = 0; k < 4; k++) run_master(k[0], k[1], k[0] ^ k[1]);
    run_b2b();
    run_abort();
    run_fault();
    run_slave();
    results();
  end
endmodule : spi_master_slave_shift_core_test
